// ===== design/pxb_pkg.sv
package pxb_pkg;

   // ---------------------------------------------------------------
   // Port shape
   // ---------------------------------------------------------------
   localparam int NUM_PINS = 8;
   localparam int WALK_LEN = 9;
   localparam logic [2:0] TX_PIN = 3'h4;
   localparam logic [2:0] RX_PIN = 3'h5;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SKIP = 8'h00;
   localparam logic [7:0] ADDR_SEL_A = 8'h04;
   localparam logic [7:0] ADDR_SEL_B = 8'h08;
   localparam logic [7:0] ADDR_IN_MODE = 8'h0C;
   localparam logic [7:0] ADDR_OUT_MODE = 8'h10;
   localparam logic [7:0] ADDR_PORT = 8'h14;
   localparam logic [7:0] ADDR_EXT_INT = 8'h18;

   // ---------------------------------------------------------------
   // Reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_SKIP = 8'h00;
   localparam logic [7:0] RST_SEL_A = 8'h00;
   localparam logic [7:0] RST_SEL_B = 8'h00;
   localparam logic [7:0] RST_IN_MODE = 8'hFF;
   localparam logic [7:0] RST_OUT_MODE = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'hFF;
   localparam logic [7:0] RST_EXT_INT = 8'h00;
   localparam logic [7:0] MASK_SKIP = 8'h7F;
   localparam logic [7:0] MASK_SEL_B = 8'hC7;
   localparam logic [7:0] MASK_EXT_INT = 8'h77;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SELA_TX_BIT = 0;
   localparam int SELA_RX_BIT = 1;
   localparam int SELA_SMB_BIT = 2;
   localparam int SELA_SYSCK_BIT = 3;
   localparam int SELA_CP_BIT = 4;
   localparam int SELA_CPA_BIT = 5;
   localparam int SELA_CEX_LO = 6;
   localparam int SELA_CEX_HI = 7;
   localparam int SELB_ECI_BIT = 0;
   localparam int SELB_T0_BIT = 1;
   localparam int SELB_T1_BIT = 2;
   localparam int SELB_ENABLE_BIT = 6;
   localparam int SELB_PUD_BIT = 7;
   localparam int EXT0_LSB = 0;
   localparam int EXT1_LSB = 4;

   // ---------------------------------------------------------------
   // Pin functions
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      FN_GPIO = 4'h0,
      FN_TX = 4'h1,
      FN_RX = 4'h2,
      FN_SDA = 4'h3,
      FN_SCL = 4'h4,
      FN_CP = 4'h5,
      FN_CPA = 4'h6,
      FN_SYSCLK = 4'h7,
      FN_CEX0 = 4'h8,
      FN_CEX1 = 4'h9,
      FN_CEX2 = 4'hA,
      FN_ECI = 4'hB,
      FN_T0 = 4'hC,
      FN_T1 = 4'hD
   } pxb_func_type;

   localparam pxb_func_type WALK_ORDER [WALK_LEN] = '{
      FN_CP, FN_CPA, FN_SYSCLK, FN_CEX0, FN_CEX1, FN_CEX2, FN_ECI, FN_T0, FN_T1
   };

endpackage : pxb_pkg

// ===== design/pxb_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_decoder (
   input wire logic [7:0] skip_mask,
   input wire logic [7:0] select_a,
   input wire logic [7:0] select_b,
   output var pxb_pkg::pxb_func_type pin_func [pxb_pkg::NUM_PINS]
);
   import pxb_pkg::*;

   // ---------------------------------------------------------------
   // Lowest free pin: {found, index}
   // ---------------------------------------------------------------
   function automatic logic [3:0] first_free(input logic [7:0] occ);
      logic [3:0] res;
      res = 4'h0;
      for (int i = NUM_PINS - 1; i >= 0; i--) begin
         if (!occ[i]) begin
            res = {1'b1, 3'(i)};
         end
      end
      return res;
   endfunction : first_free

   logic [WALK_LEN-1:0] req;

   assign req = {select_b[SELB_T1_BIT], select_b[SELB_T0_BIT], select_b[SELB_ECI_BIT],
                 &select_a[SELA_CEX_HI:SELA_CEX_LO], select_a[SELA_CEX_HI],
                 |select_a[SELA_CEX_HI:SELA_CEX_LO], select_a[SELA_SYSCK_BIT],
                 select_a[SELA_CPA_BIT], select_a[SELA_CP_BIT]};

   // ---------------------------------------------------------------
   // Priority walk
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] occ;
      logic [3:0] a;
      logic [3:0] b;
      occ = skip_mask;
      a = 4'h0;
      b = 4'h0;
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_func[i] = FN_GPIO;
      end
      if (select_b[SELB_ENABLE_BIT]) begin
         // Serial pins are fixed so a bootloader always finds them
         if (select_a[SELA_TX_BIT]) begin
            pin_func[TX_PIN] = FN_TX;
            occ[TX_PIN] = 1'b1;
         end
         if (select_a[SELA_RX_BIT]) begin
            pin_func[RX_PIN] = FN_RX;
            occ[RX_PIN] = 1'b1;
         end
         if (select_a[SELA_SMB_BIT]) begin
            a = first_free(occ);
            b = first_free(occ | (8'h01 << a[2:0]));
            // Both lines or neither; a lone data line would be useless
            if (a[3] && b[3]) begin
               pin_func[a[2:0]] = FN_SDA;
               pin_func[b[2:0]] = FN_SCL;
               occ[a[2:0]] = 1'b1;
               occ[b[2:0]] = 1'b1;
            end
         end
         for (int r = 0; r < WALK_LEN; r++) begin
            if (req[r]) begin
               a = first_free(occ);
               if (a[3]) begin
                  pin_func[a[2:0]] = WALK_ORDER[r];
                  occ[a[2:0]] = 1'b1;
               end
            end
         end
      end
   end

endmodule : pxb_decoder
`default_nettype wire

// ===== design/pxb_crossbar.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Walk peripherals, lowest free pin each
// - Serial transmit pin 4, receive 5
// - Assigned pins excluded from later search
// - Skipped pins treated as occupied
// - Bus takes two free pins together
// - Leftover pins act as general I/O
// - Enable bit activates routing; else inputs
// - Disabled matrix keeps every driver off
// - Input mode 1 digital; resets to 1
// - Analog pin: pullup, driver, receiver off
// - Output mode bit applies to routed pins
// - Bus pins always open drain
// - Pullups on open-drain unless disabled
// - Pullup off while driving low
// - Edge events on digital pins only
// - Two edge sources, any pin selectable
// - Skip bit one excludes its pin, except fixed serial pins 4 and 5; bit 7 is not writable, so pin 7 is never skipped
// - Analog pin reads back zero
// - Mode one push-pull, else open drain
// - Channel field routes none to three
module pxb_crossbar (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_transmit_output,
   output logic serial_receive_input,
   input wire logic smb_data_out,
   input wire logic smb_clock_out,
   output logic smb_data_in,
   output logic smb_clock_in,
   input wire logic comparator_output,
   input wire logic comparator_async_output,
   input wire logic sysclk_output,
   input wire logic [2:0] counter_array_channels_out,
   output logic [2:0] counter_array_channels_in,
   output logic counter_array_ext_clock,
   output logic timer0_input,
   output logic timer1_input,
   output logic [1:0] ext_event,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pin_pullup,
   output logic [7:0] pin_rx_enable
);
   import pxb_pkg::*;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] pin_skip_mask;
   logic [7:0] peripheral_select_a;
   logic [7:0] peripheral_select_b;
   logic [7:0] pin_input_mode_bits;
   logic [7:0] pin_output_mode_bits;
   logic [7:0] port_latch;
   logic [7:0] ext_interrupt_pin_config;
   logic [7:0] pad_q;
   logic [7:0] pad_prev;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic [7:0] rd_byte;
   logic matrix_enable_bit;
   logic pullup_disable_bit;

   assign matrix_enable_bit = peripheral_select_b[SELB_ENABLE_BIT];
   assign pullup_disable_bit = peripheral_select_b[SELB_PUD_BIT];
   // No wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;

   always_comb begin
      addr_ok = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr)
         ADDR_SKIP: rd_byte = pin_skip_mask;
         ADDR_SEL_A: rd_byte = peripheral_select_a;
         ADDR_SEL_B: rd_byte = peripheral_select_b;
         ADDR_IN_MODE: rd_byte = pin_input_mode_bits;
         ADDR_OUT_MODE: rd_byte = pin_output_mode_bits;
         ADDR_PORT: rd_byte = pad_q;
         ADDR_EXT_INT: rd_byte = ext_interrupt_pin_config;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         prdata <= {24'h00_0000, rd_byte};
         pslverr <= ~addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_skip_mask <= RST_SKIP;
         peripheral_select_a <= RST_SEL_A;
         peripheral_select_b <= RST_SEL_B;
         pin_input_mode_bits <= RST_IN_MODE;
         pin_output_mode_bits <= RST_OUT_MODE;
         port_latch <= RST_LATCH;
         ext_interrupt_pin_config <= RST_EXT_INT;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_SKIP: pin_skip_mask <= pwdata[7:0] & MASK_SKIP;
            ADDR_SEL_A: peripheral_select_a <= pwdata[7:0];
            ADDR_SEL_B: peripheral_select_b <= pwdata[7:0] & MASK_SEL_B;
            ADDR_IN_MODE: pin_input_mode_bits <= pwdata[7:0];
            ADDR_OUT_MODE: pin_output_mode_bits <= pwdata[7:0];
            ADDR_PORT: port_latch <= pwdata[7:0];
            ADDR_EXT_INT: ext_interrupt_pin_config <= pwdata[7:0] & MASK_EXT_INT;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin assignment
   // ---------------------------------------------------------------
   pxb_func_type pin_func [NUM_PINS];

   pxb_decoder u_decoder (
      .skip_mask(pin_skip_mask),
      .select_a(peripheral_select_a),
      .select_b(peripheral_select_b),
      .pin_func(pin_func)
   );

   // ---------------------------------------------------------------
   // Pad control per pin
   // ---------------------------------------------------------------
   logic [7:0] drive_val;
   logic [7:0] input_only;
   logic [7:0] smb_mask;
   logic [7:0] open_drain;
   logic [7:0] pp_drive;
   logic [7:0] routed_mask;
   logic [7:0] next_pin_oe;
   logic [7:0] next_pin_out;
   logic [7:0] next_pin_pullup;
   logic [7:0] m_rx;
   logic [7:0] m_sda;
   logic [7:0] m_scl;
   logic [7:0] m_eci;
   logic [7:0] m_t0;
   logic [7:0] m_t1;
   logic [7:0] m_cex [3];

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_comb begin
         drive_val[i] = 1'b1;
         input_only[i] = 1'b0;
         unique case (pin_func[i])
            FN_GPIO: drive_val[i] = port_latch[i];
            FN_TX: drive_val[i] = serial_transmit_output;
            FN_RX: input_only[i] = 1'b1;
            FN_SDA: drive_val[i] = smb_data_out;
            FN_SCL: drive_val[i] = smb_clock_out;
            FN_CP: drive_val[i] = comparator_output;
            FN_CPA: drive_val[i] = comparator_async_output;
            FN_SYSCLK: drive_val[i] = sysclk_output;
            FN_CEX0: drive_val[i] = counter_array_channels_out[0];
            FN_CEX1: drive_val[i] = counter_array_channels_out[1];
            FN_CEX2: drive_val[i] = counter_array_channels_out[2];
            FN_ECI: input_only[i] = 1'b1;
            FN_T0: input_only[i] = 1'b1;
            FN_T1: input_only[i] = 1'b1;
            default: input_only[i] = 1'b1;
         endcase
      end
      assign smb_mask[i] = (pin_func[i] == FN_SDA) | (pin_func[i] == FN_SCL);
      assign open_drain[i] = ~pin_output_mode_bits[i] | smb_mask[i];
      assign pp_drive[i] = matrix_enable_bit & pin_input_mode_bits[i] & ~input_only[i]
                           & ~open_drain[i];
      // Driver only when enabled and digital; open drain only sinks
      assign next_pin_oe[i] = matrix_enable_bit & pin_input_mode_bits[i] & ~input_only[i]
                              & (open_drain[i] ? ~drive_val[i] : 1'b1);
      assign next_pin_out[i] = ~open_drain[i] & drive_val[i];
      // Pullup only on an undriven digital pad, so never against a low
      assign next_pin_pullup[i] = pin_input_mode_bits[i] & ~pullup_disable_bit
                                  & ~next_pin_oe[i];
      assign routed_mask[i] = pin_func[i] != FN_GPIO;
      assign m_rx[i] = pin_func[i] == FN_RX;
      assign m_sda[i] = pin_func[i] == FN_SDA;
      assign m_scl[i] = pin_func[i] == FN_SCL;
      assign m_eci[i] = pin_func[i] == FN_ECI;
      assign m_t0[i] = pin_func[i] == FN_T0;
      assign m_t1[i] = pin_func[i] == FN_T1;
      assign m_cex[0][i] = pin_func[i] == FN_CEX0;
      assign m_cex[1][i] = pin_func[i] == FN_CEX1;
      assign m_cex[2][i] = pin_func[i] == FN_CEX2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_oe <= 8'h00;
         pin_out <= 8'h00;
         pin_pullup <= 8'hFF;
         pin_rx_enable <= 8'hFF;
      end else begin
         pin_oe <= next_pin_oe;
         pin_out <= next_pin_out & next_pin_oe;
         pin_pullup <= next_pin_pullup;
         pin_rx_enable <= pin_input_mode_bits;
      end
   end

   // ---------------------------------------------------------------
   // Pad sampling and peripheral inputs
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle pads sit high under their pullups; no false edge at release
         pad_q <= 8'hFF;
         pad_prev <= 8'hFF;
      end else begin
         pad_q <= pin_in & pin_input_mode_bits;
         pad_prev <= pad_q;
      end
   end

   // Unrouted inputs rest at their idle level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_receive_input <= 1'b1;
         smb_data_in <= 1'b1;
         smb_clock_in <= 1'b1;
         counter_array_ext_clock <= 1'b0;
         timer0_input <= 1'b0;
         timer1_input <= 1'b0;
         counter_array_channels_in <= 3'h0;
      end else begin
         serial_receive_input <= (|m_rx) ? |(m_rx & pad_q) : 1'b1;
         smb_data_in <= (|m_sda) ? |(m_sda & pad_q) : 1'b1;
         smb_clock_in <= (|m_scl) ? |(m_scl & pad_q) : 1'b1;
         counter_array_ext_clock <= |(m_eci & pad_q);
         timer0_input <= |(m_t0 & pad_q);
         timer1_input <= |(m_t1 & pad_q);
         for (int c = 0; c < 3; c++) begin
            counter_array_channels_in[c] <= |(m_cex[c] & pad_q);
         end
      end
   end

   // ---------------------------------------------------------------
   // External edge events
   // ---------------------------------------------------------------
   logic [2:0] ext_pin [2];
   logic [1:0] ev_raw;

   assign ext_pin[0] = ext_interrupt_pin_config[EXT0_LSB +: 3];
   assign ext_pin[1] = ext_interrupt_pin_config[EXT1_LSB +: 3];

   // Works on skipped and routed pins alike; the skip mask is not consulted
   for (genvar e = 0; e < 2; e++) begin : g_event
      assign ev_raw[e] = pin_input_mode_bits[ext_pin[e]]
                         & (pad_q[ext_pin[e]] ^ pad_prev[ext_pin[e]]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_event <= 2'h0;
      end else begin
         ext_event <= ev_raw;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence write_to(logic [7:0] addr);
      psel && penable && pwrite && paddr == addr;
   endsequence

   sequence port_read_setup;
      psel && !penable && !pwrite && paddr == ADDR_PORT;
   endsequence

   enable_follows_a: assert property (write_to(ADDR_SEL_B) ##0 pwdata[SELB_ENABLE_BIT]
      |=> matrix_enable_bit
      && (!peripheral_select_a[SELA_TX_BIT] || pin_func[TX_PIN] == FN_TX))
      else $error("matrix enable write did not take");

   disabled_quiet_a: assert property (!matrix_enable_bit |=> pin_oe == 8'h00)
      else $error("pin driven while matrix disabled");

   analog_off_a: assert property (1'b1 |=> ((pin_oe | pin_pullup | pin_rx_enable)
      & ~$past(pin_input_mode_bits)) == 8'h00)
      else $error("analog pin not fully isolated");

   bus_drain_a: assert property (1'b1 |=> (pin_out & $past(smb_mask)) == 8'h00)
      else $error("bus pin driven high");

   low_pullup_a: assert property ((pin_oe & ~pin_out & pin_pullup) == 8'h00)
      else $error("pullup on while driving low");

   push_pull_a: assert property (1'b1 |=> (pin_oe & $past(pp_drive)) == $past(pp_drive))
      else $error("push-pull pin not driven");

   skip_free_a: assert property (
      (routed_mask & pin_skip_mask & ~(m_rx | (8'h01 << TX_PIN))) == 8'h00)
      else $error("skipped pin given to a peripheral");

   uart_pin_a: assert property (matrix_enable_bit && peripheral_select_a[SELA_TX_BIT]
      |-> pin_func[TX_PIN] == FN_TX)
      else $error("serial transmit not on fixed pin");

   bus_pair_a: assert property ($countones(m_sda) == $countones(m_scl))
      else $error("bus lines not paired");

   analog_read_a: assert property (port_read_setup
      |=> (prdata[7:0] & ~$past(pin_input_mode_bits, 2)) == 8'h00)
      else $error("analog pin read nonzero");

   edge_analog_a: assert property (!pin_input_mode_bits[ext_pin[0]] |=> !ext_event[0])
      else $error("edge event on analog pin");

endmodule : pxb_crossbar
`default_nettype wire

// ===== test/pxb_pads.sv
`timescale 1ns/100ps
`default_nettype none
module pxb_pads (
   input wire logic pclk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pullup,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_in
);
   // ---------------------------------------------------------------
   // Pad resolution
   // ---------------------------------------------------------------
   logic float_q = 1'b0;

   // A released pad with no pullup wanders, so stale levels never pass for data
   always @(posedge pclk) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i]
                     : ext_en[i] ? ext_val[i] : pin_pullup[i] | float_q;
      end
   end
endmodule : pxb_pads
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pxb_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic serial_transmit_output, serial_receive_input, smb_data_out, smb_clock_out;
   logic smb_data_in, smb_clock_in, comparator_output, comparator_async_output;
   logic sysclk_output, counter_array_ext_clock, timer0_input, timer1_input;
   logic [2:0] counter_array_channels_out, counter_array_channels_in;
   logic [1:0] ext_event;
   logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_rx_enable, ext_en, ext_val;
   int n_mismatch = 0;
   int compares = 0;

   pxb_crossbar u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .serial_transmit_output, .serial_receive_input, .smb_data_out,
      .smb_clock_out, .smb_data_in, .smb_clock_in, .comparator_output,
      .comparator_async_output, .sysclk_output, .counter_array_channels_out,
      .counter_array_channels_in, .counter_array_ext_clock, .timer0_input, .timer1_input,
      .ext_event, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_rx_enable);
   pxb_pads u_pads (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);

   always #4 pclk = ~pclk;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h000000, d}, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(r, exp, "read data");
      chk({31'h0, e}, {31'h0, exp_err}, "slave error");
   endtask : rd_chk

   // Config reaches the pins one stage late, pad inputs two more
   task automatic settle();
      repeat (4) @(posedge pclk);
      #1;
   endtask : settle

   task automatic conclude();
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values();
      rd_chk(ADDR_SKIP, {24'h0, RST_SKIP}, 1'b0);
      rd_chk(ADDR_IN_MODE, {24'h0, RST_IN_MODE}, 1'b0);
      rd_chk(ADDR_OUT_MODE, {24'h0, RST_OUT_MODE}, 1'b0);
      rd_chk(ADDR_SEL_B, {24'h0, RST_SEL_B}, 1'b0);
      rd_chk(8'h1C, 32'h00000000, 1'b1);
      wr(ADDR_SKIP, 8'hFF);
      rd_chk(ADDR_SKIP, {24'h0, MASK_SKIP}, 1'b0);
      wr(ADDR_SKIP, 8'h00);
      #1;
      chk(pin_rx_enable, 8'hFF, "rx enable");
      chk(pin_pullup, 8'hFF, "pullups");
   endtask : t_reset_values

   task automatic t_disabled();
      wr(ADDR_OUT_MODE, 8'hFF);
      wr(ADDR_SEL_A, 8'h01);
      settle();
      chk(pin_oe, 8'h00, "drivers while disabled");
   endtask : t_disabled

   task automatic t_walk_skip();
      wr(ADDR_IN_MODE, 8'hFE);
      wr(ADDR_SKIP, 8'h01);
      wr(ADDR_SEL_A, 8'hD7);
      ext_en <= 8'h20;
      ext_val <= 8'h00;
      wr(ADDR_SEL_B, 8'h40);
      settle();
      chk(pin_oe, 8'hDA, "walk drivers");
      chk(pin_out & pin_oe, 8'hC8, "walk values");
      chk(pin_pullup, 8'h24, "walk pullups");
      chk(pin_rx_enable, 8'hFE, "analog receiver");
      chk(serial_receive_input, 1'b0, "serial receive");
      chk(smb_clock_in, 1'b1, "bus clock pad");
      chk(smb_data_in, 1'b0, "bus data pad");
      chk(counter_array_channels_in, 3'b011, "channels");
      rd_chk(ADDR_PORT, 32'h000000CC, 1'b0);
   endtask : t_walk_skip

   task automatic t_walk_order();
      wr(ADDR_IN_MODE, 8'hFF);
      wr(ADDR_SKIP, 8'h00);
      wr(ADDR_SEL_B, 8'h42);
      ext_val <= 8'h20;
      wr(ADDR_SEL_A, 8'h3C);
      settle();
      chk(pin_oe, 8'hDD, "order drivers");
      chk(pin_out & pin_oe, 8'hD4, "order values");
      chk(timer0_input, 1'b1, "timer0 input");
      chk(timer1_input, 1'b0, "timer1 input");
      chk(counter_array_ext_clock, 1'b0, "ext clock");
      wr(ADDR_SEL_A, 8'h80);
      settle();
      chk(pin_oe, 8'hFB, "two channels");
      wr(ADDR_SEL_B, 8'hC2);
      settle();
      chk(pin_pullup, 8'h00, "pullups disabled");
   endtask : t_walk_order

   task automatic t_events();
      int c0;
      int c1;
      c0 = 0;
      c1 = 0;
      wr(ADDR_OUT_MODE, 8'h00);
      wr(ADDR_SEL_A, 8'h00);
      wr(ADDR_IN_MODE, 8'hFE);
      wr(ADDR_EXT_INT, 8'h05);
      ext_en <= 8'h21;
      settle();
      settle();
      @(posedge pclk);
      ext_val <= 8'h01;
      repeat (8) begin
         @(posedge pclk);
         #1;
         c0 += (ext_event[0] === 1'b1);
         c1 += (ext_event[1] === 1'b1);
      end
      chk(c0, 1, "event on digital pin");
      chk(c1, 0, "event on analog pin");
   endtask : t_events

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      serial_transmit_output = 1'b0;
      smb_data_out = 1'b0;
      smb_clock_out = 1'b1;
      comparator_output = 1'b1;
      comparator_async_output = 1'b0;
      sysclk_output = 1'b1;
      counter_array_channels_out = 3'b011;
      ext_en = 8'h00;
      ext_val = 8'h00;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Software order in t_walk_skip: modes, skip, selections, enable last; t_walk_order enables before selection A
      t_reset_values();
      t_disabled();
      t_walk_skip();
      t_walk_order();
      t_events();
      conclude();
   end

   // Whole run is about a hundred cycles; this is generous
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
endmodule : tb
`default_nettype wire
